// [logic/swd_device.sv]
// Device end: serial frame decoder, configuration registers, wetting timers
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "swd_params.svh"
module swd_device
    import swd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    swd_link_if.device link,
    input wire logic normal_mode,
    input wire logic logic_supply_ok,
    input wire logic [21:0] comparator_closed,
    output logic [21:0] wake_enable,
    output logic [21:0] change_irq,
    output logic [21:0] current_on,
    output logic [21:0] current_high,
    output logic [21:0] current_pullup,
    output logic [21:0] comparator_status,
    output logic analog_enable,
    output logic [4:0] analog_selector_output
);
    localparam logic [31:0] WET_CYC = 32'(`SWD_WET_CYCLES);

    // ====================
    // State
    typedef struct packed {
        logic [2:0] sclk_s;
        logic [2:0] cs_s;
        logic [1:0] mosi_s;
        logic [1:0] mode_s;
        logic [1:0] supply_s;
        logic [23:0] shift;
        logic [4:0] nbits;
        logic miso;
        logic [21:0] wake;
        logic [21:0] level;
        logic [21:0] timer_en;
        logic [21:0] hiz;
        logic [6:0] analog;
        logic [21:0] expired;
        logic [21:0][20:0] cnt;
        logic [21:0] closed_s1;
        logic [21:0] closed_s2;
        logic [21:0] closed_p;
        logic [21:0] irq;
        logic [21:0] on;
        logic [21:0] high;
        logic [21:0] pull;
        logic [21:0] stat;
        logic aen;
        logic [4:0] asel;
    } swd_dev_type;

    swd_dev_type s_q, s_d;
    logic sclk_rise, sclk_fall, cs_rise;
    logic wr_ok;
    logic [7:0] cmd;
    logic [21:0] asel_mask;
    logic [4:0] ch;
    logic [1:0] acur;

    assign sclk_rise = s_q.sclk_s[1] & ~s_q.sclk_s[2];
    assign sclk_fall = ~s_q.sclk_s[1] & s_q.sclk_s[2];
    assign cs_rise = s_q.cs_s[1] & ~s_q.cs_s[2];
    assign cmd = s_q.shift[`SWD_CMD_MSB:`SWD_CMD_LSB];
    assign ch = s_q.analog[4:0];
    assign acur = s_q.analog[6:5];

    // ====================
    // Next state
    always_comb begin
        s_d = s_q;
        // Pins pass two stages; third sclk/cs stage only marks edges
        s_d.sclk_s = {s_q.sclk_s[1:0], link.sclk};
        s_d.cs_s = {s_q.cs_s[1:0], link.cs_n};
        s_d.mosi_s = {s_q.mosi_s[0], link.mosi};
        s_d.mode_s = {s_q.mode_s[0], normal_mode};
        s_d.supply_s = {s_q.supply_s[0], logic_supply_ok};
        wr_ok = 1'b0;
        asel_mask = '0;
        // Frame shifter, MSB first
        if (s_q.cs_s[1]) begin
            s_d.nbits = '0;
        end else if (sclk_rise) begin
            s_d.shift = {s_q.shift[22:0], s_q.mosi_s[1]};
            if (s_q.nbits != 5'd31) begin
                s_d.nbits = s_q.nbits + 5'd1;
            end
        end
        // Status out: miso forced low on every sclk falling edge within a frame
        if (sclk_fall && !s_q.cs_s[1]) begin
            s_d.miso = 1'b0;
        end
        // Commit on chip select release after exactly 24 bits
        wr_ok = cs_rise && s_q.nbits == 5'(`SWD_FRAME_BITS)
            && s_q.mode_s[1] && s_q.supply_s[1];
        if (wr_ok) begin
            unique case (cmd)
                `SWD_CMD_WAKE_PROG: s_d.wake[21:14] = s_q.shift[7:0];
                `SWD_CMD_WAKE_GND: s_d.wake[13:0] = s_q.shift[13:0];
                `SWD_CMD_LEVEL_PROG: s_d.level[21:14] = s_q.shift[7:0];
                `SWD_CMD_LEVEL_GND: s_d.level[13:0] = s_q.shift[13:0];
                `SWD_CMD_TIMER_PROG: s_d.timer_en[21:14] = s_q.shift[7:0];
                `SWD_CMD_TIMER_GND: s_d.timer_en[13:0] = s_q.shift[13:0];
                `SWD_CMD_HIZ_PROG: s_d.hiz[21:14] = s_q.shift[7:0];
                `SWD_CMD_HIZ_GND: s_d.hiz[13:0] = s_q.shift[13:0];
                `SWD_CMD_ANALOG: s_d.analog = s_q.shift[6:0];
                default: begin
                end
            endcase
        end
        // Channel decode: ground inputs at bits 13..0, programmable at 21..14
        if (ch >= `SWD_CH_GND_FIRST && ch < `SWD_CH_PROG_FIRST) begin
            asel_mask[5'(ch - `SWD_CH_GND_FIRST)] = 1'b1;
        end else if (ch >= `SWD_CH_PROG_FIRST && ch <= `SWD_CH_LAST) begin
            asel_mask[5'(ch - `SWD_CH_PROG_FIRST + 5'd14)] = 1'b1;
        end
        s_d.aen = ch != 5'h00 && ch <= `SWD_CH_LAST;
        s_d.asel = s_d.aen ? ch : 5'h00;
        // Comparator state, wetting timers and current drive
        s_d.closed_s1 = comparator_closed;
        s_d.closed_s2 = s_q.closed_s1;
        s_d.closed_p = s_q.closed_s2;
        for (int i = 0; i < `SWD_NIN; i++) begin
            if (s_q.closed_s2[i] != s_q.closed_p[i]) begin
                s_d.cnt[i] = '0;
                s_d.expired[i] = 1'b0;
            end else if (!s_q.expired[i]) begin
                if (32'(s_q.cnt[i]) >= WET_CYC - 32'd1) begin
                    s_d.expired[i] = 1'b1;
                end else begin
                    s_d.cnt[i] = s_q.cnt[i] + 21'd1;
                end
            end
            s_d.irq[i] = s_q.wake[i] && (s_q.closed_s2[i] != s_q.closed_p[i]);
            if (asel_mask[i]) begin
                s_d.on[i] = acur == 2'b01 || acur == 2'b10;
                s_d.high[i] = acur == 2'b10;
                s_d.pull[i] = 1'b1;
            end else if (s_q.hiz[i]) begin
                s_d.on[i] = 1'b0;
                s_d.high[i] = 1'b0;
                s_d.pull[i] = 1'b1;
            end else begin
                s_d.on[i] = 1'b1;
                // Level 1 high current until enabled timer expires on closure
                s_d.high[i] = s_q.level[i] && !(s_q.timer_en[i] && s_q.expired[i]
                    && s_q.closed_s2[i]);
                s_d.pull[i] = 1'b1;
            end
            s_d.stat[i] = s_q.closed_s2[i] && !asel_mask[i];
        end
    end

    // ====================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.sclk_s <= 3'h0;
            s_q.cs_s <= 3'h7;
            s_q.wake <= {`SWD_PROG_RST, `SWD_GND_RST};
            s_q.level <= {`SWD_PROG_RST, `SWD_GND_RST};
            s_q.timer_en <= {`SWD_PROG_RST, `SWD_GND_RST};
            s_q.hiz <= {`SWD_PROG_RST, `SWD_GND_RST};
            s_q.analog <= `SWD_ANALOG_RST;
            s_q.expired <= '0;
            s_q.pull <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    // ====================
    // Outputs
    assign link.miso = s_q.miso;
    assign wake_enable = s_q.wake;
    assign change_irq = s_q.irq;
    assign current_on = s_q.on;
    assign current_high = s_q.high;
    assign current_pullup = s_q.pull;
    assign comparator_status = s_q.stat;
    assign analog_enable = s_q.aen;
    assign analog_selector_output = s_q.asel;
endmodule

// [logic/swd_params.svh]
// Constants for the switch input configuration decoder
`ifndef SWD_PARAMS_SVH
`define SWD_PARAMS_SVH
`define SWD_FRAME_BITS 24
`define SWD_CMD_MSB 23
`define SWD_CMD_LSB 16
`define SWD_CMD_WAKE_PROG 8'h02
`define SWD_CMD_WAKE_GND 8'h03
`define SWD_CMD_LEVEL_PROG 8'h04
`define SWD_CMD_LEVEL_GND 8'h05
`define SWD_CMD_ANALOG 8'h06
`define SWD_CMD_TIMER_PROG 8'h07
`define SWD_CMD_TIMER_GND 8'h08
`define SWD_CMD_HIZ_PROG 8'h09
`define SWD_CMD_HIZ_GND 8'h0A
`define SWD_NPROG 8
`define SWD_NGND 14
`define SWD_NIN 22
`define SWD_PROG_RST 8'hFF
`define SWD_GND_RST 14'h3FFF
`define SWD_ANALOG_RST 7'h00
`define SWD_CH_GND_FIRST 5'h01
`define SWD_CH_PROG_FIRST 5'h0F
`define SWD_CH_LAST 5'h16
`define SWD_WET_TIME_MS 20
`define SWD_CLK_MHZ 100
`define SWD_WET_CYCLES (`SWD_WET_TIME_MS * 1000 * `SWD_CLK_MHZ)
`define SWD_HOST_DIV 4
`define SWD_APB_CMD 12'h000
`define SWD_APB_STAT 12'h004
`define SWD_APB_RESP 12'h008
`endif

// [logic/swd_pkg.sv]
// Types for the switch input configuration decoder
package swd_pkg;
    typedef enum logic [1:0] {
        SWD_HIZ_TYPE_OFF,
        SWD_LOW_CURRENT,
        SWD_HIGH_CURRENT
    } swd_current_type;
    typedef enum logic [1:0] {
        SWD_H_IDLE,
        SWD_H_SHIFT,
        SWD_H_END
    } swd_hstate_type;
endpackage

// [logic/swd_link_if.sv]
// Serial link between host controller and switch decoder
`timescale 1ns/1ps
interface swd_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    modport host (output sclk, output cs_n, output mosi, input miso);
    modport device (input sclk, input cs_n, input mosi, output miso);
endinterface

// [logic/swd_host.sv]
// Host end: APB command registers driving the serial frame master
`timescale 1ns/1ps
`include "swd_params.svh"
module swd_host
    import swd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    swd_link_if.host link
);
    typedef struct packed {
        swd_hstate_type st;
        logic [23:0] tx;
        logic [23:0] rx;
        logic [4:0] nbits;
        logic [3:0] div;
        logic sclk;
        logic cs_n;
        logic mosi;
        logic [1:0] miso_s;
        logic busy;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } swd_host_type;

    swd_host_type h_q, h_d;
    logic acc;

    // ====================
    // Next state
    always_comb begin
        h_d = h_q;
        h_d.miso_s = {h_q.miso_s[0], link.miso};
        h_d.pready = 1'b0;
        h_d.pslverr = 1'b0;
        acc = psel && penable && !h_q.pready;
        if (acc) begin
            h_d.pready = 1'b1;
            h_d.prdata = 32'h0000_0000;
            unique case (paddr)
                `SWD_APB_CMD: begin
                    if (pwrite && !h_q.busy) begin
                        h_d.tx = pwdata[23:0];
                        h_d.busy = 1'b1;
                        h_d.st = SWD_H_SHIFT;
                        h_d.cs_n = 1'b0;
                        h_d.nbits = '0;
                        h_d.div = '0;
                        h_d.mosi = pwdata[23];
                    end else if (pwrite) begin
                        h_d.pslverr = 1'b1;
                    end
                end
                `SWD_APB_STAT: h_d.prdata = {31'h0, h_q.busy};
                `SWD_APB_RESP: h_d.prdata = {8'h00, h_q.rx};
                default: h_d.pslverr = 1'b1;
            endcase
        end
        unique case (h_q.st)
            SWD_H_IDLE: begin
            end
            SWD_H_SHIFT: begin
                h_d.div = h_q.div + 4'd1;
                if (h_q.div == 4'(`SWD_HOST_DIV - 1)) begin
                    h_d.div = '0;
                    h_d.sclk = ~h_q.sclk;
                    if (!h_q.sclk) begin
                        h_d.rx = {h_q.rx[22:0], h_q.miso_s[1]};
                    end else begin
                        h_d.nbits = h_q.nbits + 5'd1;
                        h_d.tx = {h_q.tx[22:0], 1'b0};
                        h_d.mosi = h_q.tx[22];
                        if (h_q.nbits == 5'(`SWD_FRAME_BITS - 1)) begin
                            h_d.st = SWD_H_END;
                        end
                    end
                end
            end
            SWD_H_END: begin
                h_d.div = h_q.div + 4'd1;
                if (h_q.div == 4'(`SWD_HOST_DIV - 1)) begin
                    h_d.cs_n = 1'b1;
                    h_d.busy = 1'b0;
                    h_d.st = SWD_H_IDLE;
                end
            end
        endcase
    end

    // ====================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h_q <= '0;
            h_q.st <= SWD_H_IDLE;
            h_q.cs_n <= 1'b1;
        end else begin
            h_q <= h_d;
        end
    end

    assign prdata = h_q.prdata;
    assign pready = h_q.pready;
    assign pslverr = h_q.pslverr;
    assign link.sclk = h_q.sclk;
    assign link.cs_n = h_q.cs_n;
    assign link.mosi = h_q.mosi;
endmodule

// [verif/swd_assertions.sv]
// Serial link checks between the host and device ends
`timescale 1ns/1ps
module swd_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso
);
    logic sclk_q;
    logic [5:0] bits_q;
    // ====================
    // Bit clock counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q <= 1'b0;
            bits_q <= 6'h00;
        end else begin
            sclk_q <= sclk;
            bits_q <= cs_n ? 6'h00 : bits_q + {5'h00, sclk & ~sclk_q};
        end
    end
    // ====================
    // Properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_open; $fell(cs_n); endsequence
    sequence s_close; $rose(cs_n); endsequence
    property p_idle_low; cs_n |-> !sclk; endproperty
    property p_open_low; s_open |-> !sclk; endproperty
    property p_len; s_close |-> bits_q == 6'h18; endproperty
    property p_hold; !cs_n && bits_q < 6'h18 |=> !cs_n; endproperty
    property p_stable; !cs_n && sclk |-> $stable(mosi); endproperty
    property p_period; $rose(sclk) |=> !$rose(sclk) [*7]; endproperty
    property p_start; s_open |-> ##[1:32] $rose(sclk); endproperty
    property p_span; s_open |-> ##[180:400] s_close; endproperty
    a_idle_low: assert property (p_idle_low) else $error("bit clock outside frame");
    a_open_low: assert property (p_open_low) else $error("frame opened with clock high");
    a_len: assert property (p_len) else $error("frame not 24 bit clocks");
    a_hold: assert property (p_hold) else $error("frame closed early");
    a_stable: assert property (p_stable) else $error("data moved while clock high");
    a_period: assert property (p_period) else $error("bit clock too fast");
    a_start: assert property (p_start) else $error("no bit clock after open");
    a_span: assert property (p_span) else $error("frame length out of range");
endmodule

// [verif/test_switch_input_config_decoder.sv]
// Top bench: host and device joined over the serial link
`timescale 1ns/1ps
`include "swd_params.svh"
module test_switch_input_config_decoder;
    typedef struct packed {
        logic [23:0] f;
        logic [21:0] wk, on, hi;
        logic [5:0] an;
    } swd_row_type;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic pready, pslverr, e;
    logic normal_mode = 1'b1, logic_supply_ok = 1'b1;
    logic [21:0] comparator_closed = 22'h00_0000, wk, on, hi, pu, st, irq, acc;
    logic an_en;
    logic [4:0] an_ch;
    int mismatches = 0, comparisons = 0;
    swd_row_type rows [0:11] = '{
        '{24'h02_00A5, {8'hA5, 14'h3FFF}, 22'h0, 22'h0, 6'h00},
        '{24'h03_F234, {8'hA5, 14'h3234}, 22'h0, 22'h0, 6'h00},
        '{24'h09_000F, {8'hA5, 14'h3234}, {8'hF0, 14'h0}, {8'hF0, 14'h0}, 6'h00},
        '{24'h0A_C001, {8'hA5, 14'h3234}, {8'hF0, 14'h3FFE}, {8'hF0, 14'h3FFE}, 6'h00},
        '{24'h04_0030, {8'hA5, 14'h3234}, {8'hF0, 14'h3FFE}, {8'h30, 14'h3FFE}, 6'h00},
        '{24'h05_0000, {8'hA5, 14'h3234}, {8'hF0, 14'h3FFE}, {8'h30, 14'h0}, 6'h00},
        '{24'h07_0000, {8'hA5, 14'h3234}, {8'hF0, 14'h3FFE}, {8'h30, 14'h0}, 6'h00},
        '{24'h08_0000, {8'hA5, 14'h3234}, {8'hF0, 14'h3FFE}, {8'h30, 14'h0}, 6'h00},
        '{24'h06_0021, {8'hA5, 14'h3234}, {8'hF0, 14'h3FFF}, {8'h30, 14'h0}, 6'h21},
        '{24'h06_004F, {8'hA5, 14'h3234}, {8'hF1, 14'h3FFE}, {8'h31, 14'h0}, 6'h2F},
        '{24'h06_0076, {8'hA5, 14'h3234}, {8'h70, 14'h3FFE}, {8'h30, 14'h0}, 6'h36},
        '{24'h06_0040, {8'hA5, 14'h3234}, {8'hF0, 14'h3FFE}, {8'h30, 14'h0}, 6'h00}};
    swd_link_if link ();
    swd_host swd_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    swd_device swd_device_i (.pclk(pclk), .presetn(presetn), .link(link),
        .normal_mode(normal_mode), .logic_supply_ok(logic_supply_ok),
        .comparator_closed(comparator_closed), .wake_enable(wk), .change_irq(irq),
        .current_on(on), .current_high(hi), .current_pullup(pu), .comparator_status(st),
        .analog_enable(an_en), .analog_selector_output(an_ch));
    swd_assertions swd_assertions_i (.pclk(pclk), .presetn(presetn), .sclk(link.sclk),
        .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));
    // ====================
    // Tasks
    task automatic chk(input string n, input logic [21:0] x, input logic [21:0] g);
        comparisons++;
        if (g !== x) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", n, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic send(input logic [23:0] f);
        do apb(1'b0, `SWD_APB_STAT, 32'h0000_0000); while (r[0] !== 1'b0);
        apb(1'b1, `SWD_APB_CMD, {8'h00, f});
        chk("cmd_err", 22'h00_0000, {21'h0, e});
        do apb(1'b0, `SWD_APB_STAT, 32'h0000_0000); while (r[0] !== 1'b0);
        repeat (8) @(posedge pclk);
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ====================
    // Clock, watchdog, sequence
    initial begin
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (30000) @(posedge pclk);
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("wake_rst", 22'h3F_FFFF, wk);
        chk("on_rst", 22'h00_0000, on);
        foreach (rows[i]) begin
            send(rows[i].f);
            chk("wake", rows[i].wk, wk);
            chk("on", rows[i].on, on);
            chk("high", rows[i].hi, hi & on);
            chk("analog", {16'h0000, rows[i].an}, {16'h0000, an_en, an_ch});
        end
        normal_mode <= 1'b0;
        send(24'h02_0000);
        normal_mode <= 1'b1;
        logic_supply_ok <= 1'b0;
        send(24'h02_0000);
        chk("wake_gate", {8'hA5, 14'h3234}, wk);
        logic_supply_ok <= 1'b1;
        apb(1'b1, `SWD_APB_CMD, 32'h0002_00FF);
        apb(1'b1, `SWD_APB_CMD, 32'h0002_0000);
        chk("busy_err", 22'h1, {21'h0, e});
        send(24'h03_3FFE);
        chk("wake_new", {8'hFF, 14'h3FFE}, wk);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk("unmapped", 22'h1, {21'h0, e});
        apb(1'b0, `SWD_APB_RESP, 32'h0000_0000);
        chk("resp", 22'h00_0000, r[21:0]);
        comparator_closed <= 22'h00_8001;
        acc = 22'h00_0000;
        repeat (12) begin
            @(posedge pclk);
            acc = acc | irq;
        end
        chk("irq", 22'h00_8000, acc & 22'h00_8001);
        chk("status_hiz", 22'h00_8001, st & 22'h00_8001);
        send(24'h06_0030);
        chk("status_an", 22'h00_0001, st & 22'h00_8001);
        chk("pullup", 22'h00_8000, pu & on & 22'h00_8000);
        report_and_stop();
    end
endmodule
